/* hdl/fag_guard.sv */
`timescale 1ns/10ps
// flash access guard with control register
module fag_guard (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // register port
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // access request
   input wire logic req_valid,
   input wire logic [1:0] req_src,
   input wire logic [1:0] req_op,
   input wire logic [16:0] req_addr,
   input wire logic [16:0] req_pc,
   // decision
   output logic grant_valid,
   output logic grant,
   output logic full_erase,
   output logic [1:0] read_wait_code,
   output logic sw_write_erase_enable
);
   logic [7:0] ctl_q, ctl_d;
   logic [7:0] limit_q, limit_d;
   logic [7:0] wlock_q, wlock_d;
   logic [7:0] rlock_q, rlock_d;
   logic [7:0] rdata_q, rdata_d;
   logic gv_q, gv_d, g_q, g_d, fe_q, fe_d;
   logic [16:0] access_limit_address;
   logic allow;
   logic fe;

   // limit on 512-byte steps
   assign access_limit_address = {limit_q, {fag_pkg::LIMIT_SHIFT{1'b0}}};
   assign read_wait_code = ctl_q[fag_pkg::RT_LSB +: 2];
   assign sw_write_erase_enable = ctl_q[fag_pkg::WE_BIT];
   assign reg_rdata = rdata_q;
   assign grant_valid = gv_q;
   assign grant = g_q;
   assign full_erase = fe_q;

   fag_judge u_judge (
      .src(req_src),
      .op(req_op),
      .addr(req_addr),
      .pc(req_pc),
      .limit_addr(access_limit_address),
      .rlock(rlock_q),
      .wlock(wlock_q),
      .sw_we(sw_write_erase_enable),
      .allow(allow),
      .full_erase(fe)
   );

   // next state; lock bytes mirror flash content held here
   always_comb begin
      ctl_d = ctl_q;
      limit_d = limit_q;
      wlock_d = wlock_q;
      rlock_d = rlock_q;
      rdata_d = 8'h00;
      gv_d = req_valid;
      g_d = req_valid && allow;
      fe_d = req_valid && fe;
      if (reg_wr) begin
         unique case (reg_addr)
            fag_pkg::REG_CTL: ctl_d = reg_wdata & fag_pkg::CTL_WMASK;
            fag_pkg::REG_LIMIT: limit_d = reg_wdata;
            fag_pkg::REG_WLOCK: wlock_d = wlock_q & reg_wdata; // only clears
            fag_pkg::REG_RLOCK: rlock_d = rlock_q & reg_wdata;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            fag_pkg::REG_CTL: rdata_d = ctl_q;
            fag_pkg::REG_LIMIT: rdata_d = limit_q;
            fag_pkg::REG_WLOCK: rdata_d = wlock_q;
            fag_pkg::REG_RLOCK: rdata_d = rlock_q;
         endcase
      end
      // granted write to a lock byte lowers bits; firmware may lock too
      if (req_valid && allow && req_op == fag_pkg::OP_WRITE) begin
         if (req_addr == fag_pkg::WLOCK_ADDR) wlock_d = wlock_d & reg_wdata;
         if (req_addr == fag_pkg::RLOCK_ADDR) rlock_d = rlock_d & reg_wdata;
      end
      // erase of lock page or full erase reopens all
      if (req_valid && allow && req_op == fag_pkg::OP_ERASE &&
          (fe || req_addr[16:10] == fag_pkg::WLOCK_ADDR[16:10])) begin
         wlock_d = fag_pkg::LOCK_RESET;
         rlock_d = fag_pkg::LOCK_RESET;
      end
   end

   // registers; limit resets to zero
   always_ff @(posedge clock) begin
      if (!rstn) begin
         ctl_q <= fag_pkg::CTL_RESET;
         limit_q <= fag_pkg::LIMIT_RESET;
         wlock_q <= fag_pkg::LOCK_RESET;
         rlock_q <= fag_pkg::LOCK_RESET;
         rdata_q <= 8'h00;
         gv_q <= 1'b0;
         g_q <= 1'b0;
         fe_q <= 1'b0;
      end else begin
         ctl_q <= ctl_d;
         limit_q <= limit_d;
         wlock_q <= wlock_d;
         rlock_q <= rlock_d;
         rdata_q <= rdata_d;
         gv_q <= gv_d;
         g_q <= g_d;
         fe_q <= fe_d;
      end
   end
endmodule // fag_guard

/* hdl/fag_pkg.sv */
// Functional notes
// - debug port: unlocked pages fully accessible
// - debug port: locked pages refused
// - lock bytes always readable over debug
// - lock byte writes always accepted over debug
// - unlocked lock page erase clears locks
// - locked lock page: only full erase
// - reserved area refused for every source
// - firmware ignores lock bytes
// - lower firmware: all but lock page erase
// - firmware never erases lock page
// - firmware may read/write lock page
// - upper firmware: pages at/above limit
// - upper firmware denied below limit, except fetches
// - fetches below limit allowed unless reserved
// - read time field bits 5..4
// - write enable bit 0 gates software
// - limit = byte shifted to 17 bits
// - uninitialised limit byte is zero
// - one lock bit per 16k block, 0 locks
package fag_pkg;
   localparam int ADDR_W = 17;
   localparam int LIMIT_SHIFT = 9;
   localparam int BLOCK_SHIFT = 14;
   localparam logic [7:0] CTL_RESET = 8'h80;
   localparam logic [7:0] CTL_WMASK = 8'h31;
   localparam int RT_LSB = 4;
   localparam int WE_BIT = 0;
   localparam logic [7:0] LIMIT_RESET = 8'h00;
   localparam logic [7:0] LOCK_RESET = 8'hff;
   localparam logic [1:0] REG_CTL = 2'h0;
   localparam logic [1:0] REG_LIMIT = 2'h1;
   localparam logic [1:0] REG_WLOCK = 2'h2;
   localparam logic [1:0] REG_RLOCK = 2'h3;
   localparam logic [16:0] WLOCK_ADDR = 17'h1_fbfe;
   localparam logic [16:0] RLOCK_ADDR = 17'h1_fbff;
   localparam logic [16:0] RSV_LO = 17'h1_fc00;
   localparam logic [1:0] OP_READ = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_ERASE = 2'h2;
   localparam logic [1:0] OP_FETCH = 2'h3;
   localparam logic [1:0] SRC_DEBUG = 2'h0;
   localparam logic [1:0] SRC_FW = 2'h1;
endpackage

/* hdl/fag_judge.sv */
`timescale 1ns/10ps
// pure decision logic for one request
module fag_judge (
   // request
   input wire logic [1:0] src,
   input wire logic [1:0] op,
   input wire logic [16:0] addr,
   input wire logic [16:0] pc,
   // state
   input wire logic [16:0] limit_addr,
   input wire logic [7:0] rlock,
   input wire logic [7:0] wlock,
   input wire logic sw_we,
   // result
   output logic allow,
   output logic full_erase
);
   logic lock_page;
   logic lock_byte;
   logic rsv;
   logic [2:0] blk;
   logic upper;
   always_comb begin
      lock_page = addr[16:10] == fag_pkg::WLOCK_ADDR[16:10];
      lock_byte = addr == fag_pkg::WLOCK_ADDR || addr == fag_pkg::RLOCK_ADDR;
      rsv = addr >= fag_pkg::RSV_LO;
      blk = addr[fag_pkg::BLOCK_SHIFT +: 3];
      upper = pc >= limit_addr;
      allow = 1'b0;
      full_erase = 1'b0;
      if (op == fag_pkg::OP_FETCH) begin
         allow = !rsv;
      end else if (rsv) begin
         allow = 1'b0;
      end else if (src == fag_pkg::SRC_DEBUG) begin
         if (op == fag_pkg::OP_READ) begin
            allow = lock_byte || rlock[blk];
         end else if (op == fag_pkg::OP_WRITE) begin
            allow = lock_byte || wlock[blk];
         end else if (lock_byte) begin
            allow = 1'b1;
            full_erase = 1'b1;
         end else begin
            allow = wlock[blk];
         end
      end else begin
         // firmware: lock bytes ignored
         allow = sw_we || op == fag_pkg::OP_READ;
         if (op == fag_pkg::OP_ERASE && lock_page) allow = 1'b0;
         if (upper && addr < limit_addr) allow = 1'b0;
         // lower partition and lock page otherwise open
      end
   end
endmodule // fag_judge

/* sim/fag_host.sv */
`timescale 1ns/10ps
// debug host or firmware requester, one request per call
module fag_host (
   input wire logic clock,
   output logic req_valid = 1'b0,
   output logic [1:0] req_src = 2'h0,
   output logic [1:0] req_op = 2'h0,
   output logic [16:0] req_addr = 17'h0,
   output logic [16:0] req_pc = 17'h0
);
   // address scrambled after release so a stale one never passes
   task automatic issue(input logic [1:0] s, o, input logic [16:0] a, p);
      @(posedge clock);
      req_valid <= 1'b1;
      req_src <= s;
      req_op <= o;
      req_addr <= a;
      req_pc <= p;
      @(posedge clock);
      req_valid <= 1'b0;
      req_addr <= ~a;
   endtask
endmodule // fag_host

/* sim/fag_guard_sva.sv */
`timescale 1ns/10ps
module fag_guard_sva (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic req_valid,
   input wire logic [1:0] req_src,
   input wire logic [1:0] req_op,
   input wire logic [16:0] req_addr,
   input wire logic [16:0] req_pc,
   input wire logic grant_valid,
   input wire logic grant,
   input wire logic full_erase,
   input wire logic [1:0] read_wait_code,
   input wire logic sw_write_erase_enable
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   logic [7:0] lim_d, lim_q;
   wire fw = req_valid && req_src == 2'h1;
   wire [16:0] lim = {lim_q, 9'h000};
   // limit shadow; only the register port moves it
   always_comb lim_d = (reg_wr && reg_addr == 2'h1) ? reg_wdata : lim_q;
   always_ff @(posedge clock) lim_q <= rstn ? lim_d : 8'h00;
   a_rsv_deny: assert property (req_valid && req_addr >= 17'h1_fc00 |=> !grant)
      else $error("reserved granted");
   a_page_erase: assert property (fw && req_op == 2'h2 && req_addr[16:10] == 7'h7e
      |=> grant_valid && !grant) else $error("lock page erased");
   a_upper_deny: assert property (fw && req_op != 2'h3 && req_pc >= lim
      && req_addr < lim |=> !grant) else $error("lower part reached");
   a_fetch_ok: assert property (fw && req_op == 2'h3 && !req_addr[16] |=> grant)
      else $error("fetch refused");
   a_we_gate: assert property (fw && req_op == 2'h1 && !sw_write_erase_enable
      |=> !grant) else $error("write not gated");
   a_full_erase: assert property (req_valid && req_src == 2'h0 && req_op == 2'h2
      && req_addr == 17'h1_fbfe |=> grant && full_erase) else $error("no full erase");
   a_fe_cause: assert property (full_erase |-> $past(req_valid) && $past(req_op) == 2'h2)
      else $error("stray full erase");
   a_ctl_fields: assert property (reg_wr && reg_addr == 2'h0 |=>
      read_wait_code == $past(reg_wdata[5:4])) else $error("read time lost");
   a_we_follow: assert property (reg_wr && reg_addr == 2'h0 |=>
      sw_write_erase_enable == $past(reg_wdata[0])) else $error("write enable lost");
   c_fw_erase: cover property (fw && req_op == 2'h2);
   c_full: cover property (full_erase);
   c_upper: cover property (fw && req_pc >= lim && req_addr < lim);
endmodule // fag_guard_sva
bind fag_guard fag_guard_sva chk (.*);

/* sim/fag_guard_tb_top.sv */
`timescale 1ns/10ps
module fag_guard_tb_top;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic req_valid, grant_valid, grant, full_erase, sw_write_erase_enable;
   logic [1:0] req_src, req_op, read_wait_code;
   logic [16:0] req_addr, req_pc;
   int mismatches = 0;
   int total_checks = 0;
   always #20 clock = ~clock;
   fag_host host (.*);
   fag_guard uut (.*);
   task automatic stop_test();
      if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         $display("[ERR] %s exp %h got %h", n, exp, got);
         mismatches++;
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rdc(input logic [1:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", reg_rdata, e);
   endtask
   task automatic rq(input logic [1:0] s, o, input logic [16:0] a, p, input logic eg);
      host.issue(s, o, a, p);
      #1 chk("grant_valid", {7'h00, grant_valid}, 8'h01);
      chk("grant", {7'h00, grant}, {7'h00, eg});
      // only a debug erase on either lock byte starts a full erase
      chk("full_erase", {7'h00, full_erase},
          {7'h00, s == 2'h0 && o == 2'h2 && (a == 17'h1_fbfe || a == 17'h1_fbff)});
   endtask
   task automatic t_regs();
      chk("read_wait_code", {6'h00, read_wait_code}, 8'h00);
      chk("sw_write_erase_enable", {7'h00, sw_write_erase_enable}, 8'h00);
      rdc(2'h0, 8'h80);
      rdc(2'h1, 8'h00);
      rdc(2'h3, 8'hff);
      wr(2'h0, 8'hff);
      #1 chk("read_wait_code", {6'h00, read_wait_code}, 8'h03);
      chk("sw_write_erase_enable", {7'h00, sw_write_erase_enable}, 8'h01);
      rdc(2'h0, 8'h31);
   endtask
   // unlocked page erase, then locked page and full erase
   task automatic t_dbg();
      wr(2'h3, 8'hfe);
      rq(2'h0, 2'h0, 17'h0_0100, 17'h0, 1'b0);
      rq(2'h0, 2'h2, 17'h1_f800, 17'h0, 1'b1);
      rdc(2'h3, 8'hff);
      wr(2'h2, 8'h7f);
      wr(2'h3, 8'h7f);
      rq(2'h0, 2'h1, 17'h1_c000, 17'h0, 1'b0);
      rq(2'h0, 2'h0, 17'h1_fbff, 17'h0, 1'b1);
      rq(2'h0, 2'h1, 17'h0_0000, 17'h0, 1'b1);
      rq(2'h0, 2'h1, 17'h1_fbfe, 17'h0, 1'b1);
      rq(2'h0, 2'h2, 17'h1_f800, 17'h0, 1'b0);
      rq(2'h0, 2'h2, 17'h1_fbfe, 17'h0, 1'b1);
      rdc(2'h2, 8'hff);
   endtask
   // all write locks set; limit at 0x2000, upper code at 0x4000
   task automatic t_fw();
      wr(2'h2, 8'h00);
      // read time drops from 11b; no cache model here, so nothing to disable
      wr(2'h0, 8'h01);
      wr(2'h1, 8'h10);
      rq(2'h1, 2'h2, 17'h0_2000, 17'h0, 1'b1);
      rq(2'h1, 2'h2, 17'h1_f800, 17'h0, 1'b0);
      rq(2'h1, 2'h1, 17'h1_fbfe, 17'h0, 1'b1);
      rq(2'h1, 2'h0, 17'h1_fc00, 17'h0, 1'b0);
      rq(2'h1, 2'h0, 17'h0_1fff, 17'h0_4000, 1'b0);
      rq(2'h1, 2'h1, 17'h0_2000, 17'h0_4000, 1'b1);
      rq(2'h1, 2'h3, 17'h0_1000, 17'h0_4000, 1'b1);
      wr(2'h0, 8'h00);
      #1 chk("sw_write_erase_enable", {7'h00, sw_write_erase_enable}, 8'h00);
      rq(2'h1, 2'h1, 17'h0_2000, 17'h0_4000, 1'b0);
   endtask
   initial begin
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      t_regs();
      t_dbg();
      t_fw();
      stop_test();
   end
   // a hang well past the 63 or so cycles needed
   initial begin
      #50000;
      mismatches++;
      stop_test();
   end
endmodule // fag_guard_tb_top
